/* File: design/cief_irq_ctrl.sv */
`timescale 1ns/1ns
module cief_irq_ctrl (
    input  wire logic                               core_clk,
    input  wire logic                               rst_b,
    input  wire logic                               psel,
    input  wire logic                               penable,
    input  wire logic                               pwrite,
    input  wire logic [cief_pkg::APB_AW-1:0]        paddr,
    input  wire logic [cief_pkg::APB_DW-1:0]        pwdata,
    output logic      [cief_pkg::APB_DW-1:0]        prdata,
    output logic                                    pready,
    output logic                                    pslverr,
    input  wire logic                               timer0_ovf,
    input  wire logic                               ext_pin,
    input  wire logic [cief_pkg::PORT_CHG_W-1:0]    port_a_change_flags,
    input  wire logic [cief_pkg::PFLAG_W-1:0]       periph_flags,
    input  wire logic                               irq_take,
    input  wire logic                               return_from_irq_instr,
    output logic                                    irq_req,
    output logic      [15:0]                        irq_vector,
    output logic                                    irq_out
);
    import cief_pkg::*;

    logic [7:0]          ctrl_ff;
    logic [7:0]          pie_ff;
    logic [EVT_W-1:0]    sts_ff;
    logic [EVT_W-1:0]    evt_en_ff;
    logic                rise_sel_ff;
    logic [APB_DW-1:0]   prdata_ff;
    logic [APB_DW-1:0]   nxt_prdata;
    logic                wr_en;
    logic                mapped;
    logic                ext_evt;
    logic                chg_now;
    logic                core_term;
    logic                periph_term;
    logic [EVT_W-1:0]    evt;

    cief_pin_if pif ();

    // --------------------------------------------------------------
    // External pin edge detection
    // --------------------------------------------------------------
    assign pif.rise_sel = rise_sel_ff;
    assign ext_evt      = pif.edge_evt;

    cief_pin_sync u_pin_sync (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .ext_pin  (ext_pin),
        .pif      (pif)
    );

    // --------------------------------------------------------------
    // APB slave, zero wait states
    // --------------------------------------------------------------
    always_comb begin
        mapped = 1'b1;
        unique case (paddr)
            OFS_CORE_CTRL: nxt_prdata = {24'h000000, ctrl_ff};
            OFS_PERIPH_EN: nxt_prdata = {24'h000000, pie_ff};
            OFS_EVT_STS:   nxt_prdata = {28'h0000000, sts_ff};
            OFS_EVT_CLR:   nxt_prdata = 32'h00000000;
            OFS_EVT_EN:    nxt_prdata = {28'h0000000, evt_en_ff};
            OFS_PIN_CFG:   nxt_prdata = {31'h00000000, rise_sel_ff};
            default: begin
                nxt_prdata = 32'h00000000;
                mapped     = 1'b0;
            end
        endcase
    end

    // Read data is sampled in setup so it stands from a flop in access
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata_ff <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata_ff <= nxt_prdata;
        end
    end

    assign prdata  = prdata_ff;
    assign pready  = psel & penable;
    assign pslverr = psel & penable & ~mapped;
    assign wr_en   = psel & penable & pwrite & mapped;

    // --------------------------------------------------------------
    // Core control register
    // --------------------------------------------------------------
    assign chg_now = |port_a_change_flags;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_ff[B_GLOBAL_EN] <= RST_CORE_CTRL[B_GLOBAL_EN];
        end else if (irq_take) begin
            ctrl_ff[B_GLOBAL_EN] <= 1'b0;
        end else if (return_from_irq_instr) begin
            ctrl_ff[B_GLOBAL_EN] <= 1'b1;
        end else if (wr_en && paddr == OFS_CORE_CTRL) begin
            ctrl_ff[B_GLOBAL_EN] <= pwdata[B_GLOBAL_EN];
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_ff[B_PERIPH_EN:B_CHG_EN] <= RST_CORE_CTRL[B_PERIPH_EN:B_CHG_EN];
        end else if (wr_en && paddr == OFS_CORE_CTRL) begin
            ctrl_ff[B_PERIPH_EN:B_CHG_EN] <= pwdata[B_PERIPH_EN:B_CHG_EN];
        end
    end

    // Hardware set wins over a software clear in the same cycle
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_ff[B_T0_FLAG]  <= RST_CORE_CTRL[B_T0_FLAG];
            ctrl_ff[B_EXT_FLAG] <= RST_CORE_CTRL[B_EXT_FLAG];
        end else begin
            if (timer0_ovf) begin
                ctrl_ff[B_T0_FLAG] <= 1'b1;
            end else if (wr_en && paddr == OFS_CORE_CTRL) begin
                ctrl_ff[B_T0_FLAG] <= pwdata[B_T0_FLAG];
            end
            if (ext_evt) begin
                ctrl_ff[B_EXT_FLAG] <= 1'b1;
            end else if (wr_en && paddr == OFS_CORE_CTRL) begin
                ctrl_ff[B_EXT_FLAG] <= pwdata[B_EXT_FLAG];
            end
        end
    end

    // Summary ignores bus writes; it drops only when every port flag has
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_ff[B_CHG_SUM] <= RST_CORE_CTRL[B_CHG_SUM];
        end else begin
            ctrl_ff[B_CHG_SUM] <= chg_now;
        end
    end

    // --------------------------------------------------------------
    // Peripheral enables and pin configuration
    // --------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pie_ff <= RST_PERIPH_EN;
        end else if (wr_en && paddr == OFS_PERIPH_EN) begin
            pie_ff <= pwdata[7:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rise_sel_ff <= RST_RISE_SEL;
        end else if (wr_en && paddr == OFS_PIN_CFG) begin
            rise_sel_ff <= pwdata[0];
        end
    end

    // --------------------------------------------------------------
    // Request to the core sequencer
    // --------------------------------------------------------------
    assign core_term   = (ctrl_ff[B_T0_EN] & ctrl_ff[B_T0_FLAG])
                       | (ctrl_ff[B_EXT_EN] & ctrl_ff[B_EXT_FLAG])
                       | (ctrl_ff[B_CHG_EN] & ctrl_ff[B_CHG_SUM]);
    assign periph_term = ctrl_ff[B_PERIPH_EN] & (|(pie_ff & periph_flags));
    assign irq_req     = ctrl_ff[B_GLOBAL_EN] & (core_term | periph_term);
    assign irq_vector  = IRQ_VECTOR;

    // --------------------------------------------------------------
    // Sticky event status, clear and enable
    // --------------------------------------------------------------
    assign evt[E_T0_SET]    = timer0_ovf;
    assign evt[E_EXT_SET]   = ext_evt;
    assign evt[E_CHG_RISE]  = chg_now & ~ctrl_ff[B_CHG_SUM];
    assign evt[E_IRQ_TAKEN] = irq_take;

    genvar gi;
    generate
        for (gi = 0; gi < EVT_W; gi++) begin : g_sts
            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    sts_ff[gi] <= RST_EVT[gi];
                end else if (evt[gi]) begin
                    sts_ff[gi] <= 1'b1;
                end else if (wr_en && paddr == OFS_EVT_CLR && pwdata[gi]) begin
                    sts_ff[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            evt_en_ff <= RST_EVT;
        end else if (wr_en && paddr == OFS_EVT_EN) begin
            evt_en_ff <= pwdata[EVT_W-1:0];
        end
    end

    assign irq_out = |(sts_ff & evt_en_ff);

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    property p_gie_blocks;
        @(posedge core_clk) disable iff (!rst_b)
        !ctrl_ff[B_GLOBAL_EN] |-> !irq_req;
    endproperty
    a_gie_blocks: assert property (p_gie_blocks) else $error("request while global enable low");

    property p_peripheral_group_enable_masks;
        @(posedge core_clk) disable iff (!rst_b)
        (!ctrl_ff[B_PERIPH_EN] && !core_term) |-> !irq_req;
    endproperty
    a_peripheral_group_enable_masks: assert property (p_peripheral_group_enable_masks) else $error("peripheral request not masked");

    property p_t0_local;
        @(posedge core_clk) disable iff (!rst_b)
        (ctrl_ff[B_GLOBAL_EN] && ctrl_ff[B_T0_EN] && ctrl_ff[B_T0_FLAG]) |-> irq_req;
    endproperty
    a_t0_local: assert property (p_t0_local) else $error("enabled timer0 flag gives no request");

    property p_t0_set;
        @(posedge core_clk) disable iff (!rst_b)
        timer0_ovf |=> ctrl_ff[B_T0_FLAG] ##1 (ctrl_ff[B_T0_FLAG] || $past(wr_en));
    endproperty
    a_t0_set: assert property (p_t0_set) else $error("timer0 flag not set or lost");

    property p_ext_set;
        @(posedge core_clk) disable iff (!rst_b)
        (ext_evt && !ctrl_ff[B_GLOBAL_EN]) |=> ctrl_ff[B_EXT_FLAG];
    endproperty
    a_ext_set: assert property (p_ext_set) else $error("pin flag not set");

    property p_chg_sum;
        @(posedge core_clk) disable iff (!rst_b)
        ##1 ctrl_ff[B_CHG_SUM] == $past(chg_now);
    endproperty
    a_chg_sum: assert property (p_chg_sum) else $error("summary flag mismatch");

    property p_chg_ro;
        @(posedge core_clk) disable iff (!rst_b)
        (wr_en && paddr == OFS_CORE_CTRL && !chg_now) |=> !ctrl_ff[B_CHG_SUM];
    endproperty
    a_chg_ro: assert property (p_chg_ro) else $error("summary flag written by bus");

    property p_pie_wr;
        @(posedge core_clk) disable iff (!rst_b)
        (wr_en && paddr == OFS_PERIPH_EN) |=> pie_ff == $past(pwdata[7:0]);
    endproperty
    a_pie_wr: assert property (p_pie_wr) else $error("peripheral enable write lost");

    property p_take;
        @(posedge core_clk) disable iff (!rst_b)
        irq_take |=> !ctrl_ff[B_GLOBAL_EN] && !irq_req && irq_vector == 16'h0004;
    endproperty
    a_take: assert property (p_take) else $error("global enable kept after take");

    property p_return_from_irq_instr;
        @(posedge core_clk) disable iff (!rst_b)
        (return_from_irq_instr && !irq_take) |=> ctrl_ff[B_GLOBAL_EN];
    endproperty
    a_return_from_irq_instr: assert property (p_return_from_irq_instr) else $error("global enable not restored");

    property p_t0_hold;
        @(posedge core_clk) disable iff (!rst_b)
        (ctrl_ff[B_T0_FLAG] && !(wr_en && paddr == OFS_CORE_CTRL)) |=> ctrl_ff[B_T0_FLAG];
    endproperty
    a_t0_hold: assert property (p_t0_hold) else $error("timer0 flag dropped without clear");

    property p_ext_hold;
        @(posedge core_clk) disable iff (!rst_b)
        (ctrl_ff[B_EXT_FLAG] && !(wr_en && paddr == OFS_CORE_CTRL)) |=> ctrl_ff[B_EXT_FLAG];
    endproperty
    a_ext_hold: assert property (p_ext_hold) else $error("pin flag dropped without clear");

    property p_ext_any;
        @(posedge core_clk) disable iff (!rst_b)
        ext_evt |=> ctrl_ff[B_EXT_FLAG];
    endproperty
    a_ext_any: assert property (p_ext_any) else $error("pin flag gated by an enable");

    property p_periph_pass;
        @(posedge core_clk) disable iff (!rst_b)
        (ctrl_ff[B_GLOBAL_EN] && ctrl_ff[B_PERIPH_EN] && ((pie_ff & periph_flags) != 8'h00)) |-> irq_req;
    endproperty
    a_periph_pass: assert property (p_periph_pass) else $error("enabled peripheral gives no request");

    c_take: cover property (@(posedge core_clk) disable iff (!rst_b) irq_req ##1 irq_take);
    c_periph: cover property (@(posedge core_clk) disable iff (!rst_b) periph_term && irq_req);
    c_set_clr: cover property (@(posedge core_clk) disable iff (!rst_b)
        timer0_ovf && wr_en && paddr == OFS_CORE_CTRL);
    c_irq_out: cover property (@(posedge core_clk) disable iff (!rst_b) irq_out);
endmodule

/* File: design/cief_pin_if.sv */
`timescale 1ns/1ns
interface cief_pin_if;
    logic rise_sel;
    logic edge_evt;
    modport sync (input rise_sel, output edge_evt);
    modport ctrl (output rise_sel, input edge_evt);
endinterface

/* File: design/cief_pin_sync.sv */
`timescale 1ns/1ns
module cief_pin_sync (
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic ext_pin,
    cief_pin_if.sync  pif
);
    logic sync1_ff;
    logic sync2_ff;
    logic prev_ff;

    // --------------------------------------------------------------
    // Two-stage synchroniser, edge seen on the second stage only
    // --------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            prev_ff  <= 1'b0;
        end else begin
            sync1_ff <= ext_pin;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    assign pif.edge_evt = pif.rise_sel ? (sync2_ff & ~prev_ff) : (~sync2_ff & prev_ff);
endmodule

/* File: design/cief_pkg.sv */
package cief_pkg;
    // --------------------------------------------------------------
    // Bus geometry
    // --------------------------------------------------------------
    localparam int APB_AW = 8;
    localparam int APB_DW = 32;
    localparam int PFLAG_W = 8;
    localparam int PORT_CHG_W = 6;

    // --------------------------------------------------------------
    // Register byte offsets
    // --------------------------------------------------------------
    localparam logic [APB_AW-1:0] OFS_CORE_CTRL = 8'h00;
    localparam logic [APB_AW-1:0] OFS_PERIPH_EN = 8'h04;
    localparam logic [APB_AW-1:0] OFS_EVT_STS   = 8'h08;
    localparam logic [APB_AW-1:0] OFS_EVT_CLR   = 8'h0c;
    localparam logic [APB_AW-1:0] OFS_EVT_EN    = 8'h10;
    localparam logic [APB_AW-1:0] OFS_PIN_CFG   = 8'h14;

    // --------------------------------------------------------------
    // Core control field positions
    // --------------------------------------------------------------
    localparam int B_GLOBAL_EN  = 7;
    localparam int B_PERIPH_EN  = 6;
    localparam int B_T0_EN      = 5;
    localparam int B_EXT_EN     = 4;
    localparam int B_CHG_EN     = 3;
    localparam int B_T0_FLAG    = 2;
    localparam int B_EXT_FLAG   = 1;
    localparam int B_CHG_SUM    = 0;

    // --------------------------------------------------------------
    // Event status positions
    // --------------------------------------------------------------
    localparam int EVT_W        = 4;
    localparam int E_T0_SET     = 0;
    localparam int E_EXT_SET    = 1;
    localparam int E_CHG_RISE   = 2;
    localparam int E_IRQ_TAKEN  = 3;

    // --------------------------------------------------------------
    // Reset values and constants
    // --------------------------------------------------------------
    localparam logic [7:0]       RST_CORE_CTRL = 8'h00;
    localparam logic [7:0]       RST_PERIPH_EN = 8'h00;
    localparam logic [EVT_W-1:0] RST_EVT       = 4'h0;
    localparam logic             RST_RISE_SEL  = 1'b1;
    localparam logic [15:0]      IRQ_VECTOR    = 16'h0004;
endpackage

/* File: testbench/cief_core_model.sv */
`timescale 1ns/1ns
// ------------------------------------------------------------------
// Core sequencer: takes a pending request after a set wait, returns later
// ------------------------------------------------------------------
module cief_core_model (
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    input  wire logic       irq_req,
    input  wire logic       service,
    input  wire logic [2:0] wait_cyc,
    output logic            irq_take,
    output logic            return_from_irq_instr
);
    logic       in_isr_ff;
    logic [4:0] cnt_ff;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            in_isr_ff <= 1'b0;
            cnt_ff <= 5'h00;
            irq_take <= 1'b0;
            return_from_irq_instr <= 1'b0;
        end else begin
            irq_take <= 1'b0;
            return_from_irq_instr <= 1'b0;
            if (!in_isr_ff) begin
                // A request that drops while waiting is dropped, as a real core would
                if (!(service && irq_req)) begin
                    cnt_ff <= 5'h00;
                end else if (cnt_ff == {2'b00, wait_cyc}) begin
                    irq_take <= 1'b1;
                    in_isr_ff <= 1'b1;
                    cnt_ff <= 5'h00;
                end else begin
                    cnt_ff <= cnt_ff + 5'h01;
                end
            end else if (cnt_ff == {2'b00, wait_cyc} + 5'h0c) begin
                // Long stay in the handler leaves room for register reads
                return_from_irq_instr <= 1'b1;
                in_isr_ff <= 1'b0;
                cnt_ff <= 5'h00;
            end else begin
                cnt_ff <= cnt_ff + 5'h01;
            end
        end
    end
endmodule

/* File: testbench/tb_core_interrupt_enable_flags.sv */
`timescale 1ns/1ns
module tb_core_interrupt_enable_flags;
    import cief_pkg::*;
    logic                  core_clk = 1'b0;
    logic                  rst_b, psel, penable, pwrite, pready, pslverr, err;
    logic                  timer0_ovf, ext_pin, irq_take, ret_instr, irq_req, irq_out, service;
    logic [APB_AW-1:0]     paddr;
    logic [APB_DW-1:0]     pwdata, prdata, rd;
    logic [PORT_CHG_W-1:0] port_flags;
    logic [PFLAG_W-1:0]    periph_flags;
    logic [15:0]           irq_vector;
    logic [2:0]            wait_cyc;
    int                    err_total, comparisons, m_ctrl, m_pie;

    always #10 core_clk = ~core_clk;

    cief_irq_ctrl cief_irq_ctrl_i (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer0_ovf(timer0_ovf), .ext_pin(ext_pin), .port_a_change_flags(port_flags),
        .periph_flags(periph_flags), .irq_take(irq_take), .return_from_irq_instr(ret_instr),
        .irq_req(irq_req), .irq_vector(irq_vector), .irq_out(irq_out));
    cief_core_model cief_core_model_i (.core_clk(core_clk), .rst_b(rst_b), .irq_req(irq_req),
        .service(service), .wait_cyc(wait_cyc), .irq_take(irq_take), .return_from_irq_instr(ret_instr));

    // ------------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------------
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk_reg(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk_pin(input string name, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            err_total++;
            results();
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input int exp, input string name);
        apb(1'b0, a, 32'h0);
        chk_reg(name, exp, rd);
    endtask
    // Core pulses last one cycle, so they are looked for at every falling edge
    task automatic wait_hi(ref logic s);
        int k;
        k = 0;
        while (s !== 1'b1 && k < 60) begin
            @(negedge core_clk);
            k++;
        end
        if (s !== 1'b1) begin
            err_total++;
            results();
        end
    endtask
    function automatic logic exp_irq();
        return m_ctrl[7] && ((m_ctrl[2] && m_ctrl[5]) || (m_ctrl[1] && m_ctrl[4]) ||
            ((port_flags != 0) && m_ctrl[3]) || (m_ctrl[6] && ((m_pie & periph_flags) != 0)));
    endfunction

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {rst_b, psel, penable, pwrite, timer0_ovf, ext_pin, service} = 7'h00;
        {paddr, pwdata, port_flags, periph_flags, wait_cyc} = '0;
        {err_total, comparisons, m_ctrl, m_pie} = '0;
        void'($urandom(72));
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        rd_chk(OFS_CORE_CTRL, 0, "core_ctrl");
        rd_chk(OFS_PERIPH_EN, 0, "periph_en");
        rd_chk(OFS_PIN_CFG, 1, "pin_cfg");
        chk_pin("irq_req", 1'b0, irq_req);
        apb(1'b1, OFS_CORE_CTRL, 32'h0000_00ff);
        rd_chk(OFS_CORE_CTRL, 'hfe, "core_ctrl");
        rd_chk(OFS_EVT_CLR, 0, "evt_clr");
        rd_chk(8'h18, 0, "unmapped");
        chk_pin("pslverr", 1'b1, err);
        for (int i = 0; i < 24; i++) begin
            @(posedge core_clk);
            port_flags <= (i % 4 == 0) ? '0 : PORT_CHG_W'($urandom);
            periph_flags <= PFLAG_W'($urandom);
            m_pie = $urandom & 'hff;
            m_ctrl = $urandom & 'hfe;
            apb(1'b1, OFS_PERIPH_EN, m_pie);
            apb(1'b1, OFS_CORE_CTRL, m_ctrl);
            rd_chk(OFS_PERIPH_EN, m_pie, "periph_en");
            rd_chk(OFS_CORE_CTRL, m_ctrl | (port_flags != 0), "core_ctrl");
            @(negedge core_clk);
            chk_pin("irq_req", exp_irq(), irq_req);
        end
        @(posedge core_clk);
        port_flags <= '0;
        periph_flags <= '0;
        apb(1'b1, OFS_CORE_CTRL, 32'h0);
        m_ctrl = 0;
        rd_chk(OFS_CORE_CTRL, 0, "core_ctrl");
        apb(1'b1, OFS_EVT_CLR, 32'hf);
        @(posedge core_clk);
        timer0_ovf <= 1'b1;
        @(posedge core_clk);
        timer0_ovf <= 1'b0;
        rd_chk(OFS_CORE_CTRL, 'h04, "core_ctrl");
        rd_chk(OFS_EVT_STS, 'h1, "evt_sts");
        chk_pin("irq_req", 1'b0, irq_req);
        chk_pin("irq_out", 1'b0, irq_out);
        apb(1'b1, OFS_EVT_EN, 32'h1);
        @(negedge core_clk);
        chk_pin("irq_out", 1'b1, irq_out);
        apb(1'b1, OFS_EVT_CLR, 32'h1);
        @(negedge core_clk);
        chk_pin("irq_out", 1'b0, irq_out);
        rd_chk(OFS_EVT_STS, 0, "evt_sts");
        // Overflow on the very edge that a clearing write completes: the set must win
        fork
            apb(1'b1, OFS_CORE_CTRL, 32'h0);
            begin
                repeat (2) @(posedge core_clk);
                timer0_ovf <= 1'b1;
                @(posedge core_clk);
                timer0_ovf <= 1'b0;
            end
        join
        rd_chk(OFS_CORE_CTRL, 'h04, "core_ctrl");
        // Rising with rising selected, then falling and rising with falling selected
        for (int e = 0; e < 3; e++) begin
            apb(1'b1, OFS_CORE_CTRL, 32'h0);
            apb(1'b1, OFS_PIN_CFG, (e == 0));
            @(posedge core_clk);
            ext_pin <= (e != 1);
            repeat (4) @(posedge core_clk);
            rd_chk(OFS_CORE_CTRL, (e < 2) ? 'h02 : 0, "core_ctrl");
        end
        for (int w = 0; w < 8; w += 7) begin
            apb(1'b1, OFS_EVT_CLR, 32'hf);
            apb(1'b1, OFS_CORE_CTRL, 32'ha4);
            @(negedge core_clk);
            chk_pin("irq_req", 1'b1, irq_req);
            @(posedge core_clk);
            wait_cyc <= 3'(w);
            service <= 1'b1;
            wait_hi(irq_take);
            @(posedge core_clk);
            service <= 1'b0;
            chk_reg("irq_vector", 32'h4, {16'h0, irq_vector});
            @(negedge core_clk);
            chk_pin("irq_req", 1'b0, irq_req);
            rd_chk(OFS_CORE_CTRL, 'h24, "core_ctrl");
            apb(1'b0, OFS_EVT_STS, 32'h0);
            chk_reg("taken_sts", 32'h8, rd & 32'h8);
            wait_hi(ret_instr);
            rd_chk(OFS_CORE_CTRL, 'ha4, "core_ctrl");
        end
        results();
    end
endmodule
